// >>> rtl/rfc_flow_ctrl.sv
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module rfc_flow_ctrl #(
	parameter int unsigned LVL_W       = 14,
	parameter int unsigned TICK_CYCLES = rfc_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// Register port
	input  wire logic [7:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [31:0]               reg_rdata,
	// MAC link state
	input  wire logic                 full_duplex,
	input  wire logic                 speed_100,
	input  wire logic                 tx_enabled,
	// Receive side
	input  wire logic [LVL_W-1:0]     rx_fifo_level,
	input  wire rfc_pkg::rfc_rx_evt_t rx_evt,
	// Flow control requests
	output logic                      jam_req,
	output logic                      pause_req,
	output logic                      pause_zero,
	input  wire logic                 pause_ack
);
	import rfc_pkg::*;

	////////////////////////////////////////////////////////////////
	// Configuration register and read port

	rfc_cfg_t      cfg_q;
	rfc_stat_t     stat;
	rfc_fc_state_t state_q;
	logic [31:0]   rdata_q;
	logic [LVL_W-UNIT_SHIFT-1:0] units;
	logic          above_hi;
	logic          below_lo;
	logic          jam_busy;
	logic          jam_start;
	logic          jam_abort;
	logic          tick;
	logic [12:0]   load_ticks;
	logic          hd_match;
	logic          issue_hi;
	logic          issue_zero;
	logic          pause_req_q;
	logic          pause_zero_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_q <= CFG_RESET;
		end else if (reg_wr && reg_addr == ADDR_CFG) begin
			cfg_q <= reg_wdata & CFG_WMASK;
		end
	end

	always_comb begin
		stat               = '0;
		stat.level_units   = 8'(units);
		stat.pause_pending = pause_req_q;
		stat.below_lo      = below_lo;
		stat.above_hi      = above_hi;
		stat.paused        = (state_q == FC_PAUSED);
		stat.jam           = jam_busy;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				ADDR_CFG:  rdata_q <= cfg_q;
				ADDR_STAT: rdata_q <= stat;
				default:   rdata_q <= '0;
			endcase
		end else begin
			rdata_q <= '0;
		end
	end

	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////
	// FIFO level compare in 64-byte units

	assign units = rx_fifo_level[LVL_W-1:UNIT_SHIFT];

	// Trigger level [R12]
	assign above_hi = ({8'h00, units} >= {8'h00, cfg_q.hi_thr});
	// Release level, relies on low set below high [R13] [R11]
	assign below_lo = ({8'h00, units} < {8'h00, cfg_q.lo_thr});

	////////////////////////////////////////////////////////////////
	// Half duplex back pressure

	// Address-based triggers, masked by any-frame mode [R03] [R04] [R05] [R09]
	assign hd_match = !cfg_q.trg_any && rx_evt.da_valid &&
		((cfg_q.trg_mcast && rx_evt.mcast) ||
		 (cfg_q.trg_bcast && rx_evt.bcast) ||
		 (cfg_q.trg_own && rx_evt.own));

	// Any-frame mode jams on preamble, no decode [R06] [R07]
	assign jam_start = !full_duplex && tx_enabled && above_hi &&
		!jam_busy &&
		((cfg_q.trg_any && rx_evt.preamble) || hd_match); // [R14]

	// Stop jam in full duplex or with tx off [R02] [R14]
	assign jam_abort = full_duplex || !tx_enabled;

	// Duration table lookup [R10]
	assign load_ticks = rfc_dur_ticks(cfg_q.dur_code, speed_100);

	rfc_tick_div #(
		.CYCLES (TICK_CYCLES)
	) u_div (
		.core_clk (core_clk),
		.rst      (rst),
		.clr      (jam_start),
		.tick     (tick)
	);

	// Hold jam for the programmed time [R01]
	rfc_jam_timer u_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (jam_start),
		.ticks    (load_ticks),
		.abort    (jam_abort),
		.tick     (tick),
		.busy_q   (jam_busy)
	);

	assign jam_req = jam_busy;

	////////////////////////////////////////////////////////////////
	// Full duplex pause requests

	// Pause at once on reaching the level [R06] [R08] [R14]
	assign issue_hi = full_duplex && cfg_q.trg_any && tx_enabled &&
		!pause_req_q && state_q == FC_IDLE && above_hi;

	// Zero pause only after a pause went out [R13] [R14]
	assign issue_zero = full_duplex && cfg_q.trg_any && tx_enabled &&
		!pause_req_q && state_q == FC_PAUSED && below_lo;

	// One pause per crossing of the high level [R12]
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= FC_IDLE;
		end else begin
			unique case (state_q)
				FC_IDLE: begin
					if (issue_hi) begin
						state_q <= FC_PAUSED;
					end
				end
				FC_PAUSED: begin
					if (issue_zero || !full_duplex ||
						!cfg_q.trg_any) begin
						state_q <= FC_IDLE;
					end
				end
			endcase
		end
	end

	// Request held until the MAC takes it [R08]
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pause_req_q  <= 1'b0;
			pause_zero_q <= 1'b0;
		end else if (issue_hi || issue_zero) begin
			pause_req_q  <= 1'b1;
			pause_zero_q <= issue_zero;
		end else if (pause_ack) begin
			pause_req_q  <= 1'b0;
			pause_zero_q <= 1'b0;
		end
	end

	assign pause_req  = pause_req_q;
	assign pause_zero = pause_zero_q;

	////////////////////////////////////////////////////////////////
	// Checks

	logic [31:0] jam_len_q;
	logic [31:0] jam_exp_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			jam_len_q <= '0;
			jam_exp_q <= '0;
		end else if (jam_start) begin
			jam_len_q <= '0;
			jam_exp_q <= 32'(load_ticks) * TICK_CYCLES;
		end else if (jam_busy) begin
			jam_len_q <= jam_len_q + 32'h1;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (rst);

	AST_JAM_LENGTH: assert property ( // [R01]
		$fell(jam_busy) && !$past(jam_abort) |->
		jam_len_q == jam_exp_q
	) else $error("jam length differs from programmed duration");

	AST_FD_NO_JAM: assert property ( // [R02]
		full_duplex |=> !jam_busy
	) else $error("jam active in full duplex");

	AST_MCAST_JAM: assert property ( // [R03]
		!full_duplex && tx_enabled && above_hi && !jam_busy &&
		!cfg_q.trg_any && cfg_q.trg_mcast &&
		rx_evt.da_valid && rx_evt.mcast
		|=> jam_busy
	) else $error("multicast frame not jammed");

	AST_BCAST_JAM: assert property ( // [R04]
		!full_duplex && tx_enabled && above_hi && !jam_busy &&
		!cfg_q.trg_any && cfg_q.trg_bcast &&
		rx_evt.da_valid && rx_evt.bcast
		|=> jam_busy
	) else $error("broadcast frame not jammed");

	AST_OWN_JAM: assert property ( // [R05]
		!full_duplex && tx_enabled && above_hi && !jam_busy &&
		!cfg_q.trg_any && cfg_q.trg_own &&
		rx_evt.da_valid && rx_evt.own
		|=> jam_busy ##1 jam_busy
	) else $error("own address frame not jammed");

	AST_PREAMBLE_JAM: assert property ( // [R07]
		!full_duplex && tx_enabled && above_hi && !jam_busy &&
		cfg_q.trg_any && rx_evt.preamble
		|=> jam_busy
	) else $error("any-frame mode missed preamble");

	AST_ANY_OVERRIDES: assert property ( // [R09]
		!jam_busy && cfg_q.trg_any && !rx_evt.preamble
		|=> !jam_busy
	) else $error("jam started without preamble in any mode");

	AST_PAUSE_AT_HIGH: assert property ( // [R08]
		full_duplex && cfg_q.trg_any && tx_enabled && above_hi &&
		!pause_req_q && state_q == FC_IDLE
		|=> pause_req_q && !pause_zero_q
	) else $error("pause not requested at high level");

	AST_ONE_PAUSE: assert property ( // [R12]
		$rose(pause_req_q) && !pause_zero_q
		|-> $past(state_q) == FC_IDLE && $past(above_hi)
	) else $error("second pause without new crossing");

	AST_ZERO_AFTER_PAUSE: assert property ( // [R13]
		$rose(pause_req_q) && pause_zero_q
		|-> $past(state_q) == FC_PAUSED && $past(below_lo)
	) else $error("zero pause without earlier pause");

	AST_TX_OFF_QUIET: assert property ( // [R14]
		!tx_enabled && !jam_busy && !pause_req_q
		|=> !jam_busy && !pause_req_q
	) else $error("request raised with transmitter off");

	AST_REQ_HELD: assert property ( // [R08]
		pause_req_q && !pause_ack |=> pause_req_q
	) else $error("pause request dropped before ack");

	////////////////////////////////////////////////////////////////
	// Request and hold checks

	AST_ACK_CLEARS: assert property ( // [R08]
		pause_req_q && pause_ack |=> !pause_req_q
	) else $error("pause request kept after ack");

	AST_ZERO_HELD: assert property ( // [R13]
		pause_req_q && !pause_ack |=> $stable(pause_zero_q)
	) else $error("pause kind changed while pending");

	AST_ZERO_AT_LOW: assert property ( // [R13]
		full_duplex && cfg_q.trg_any && tx_enabled && below_lo &&
		!pause_req_q && state_q == FC_PAUSED
		|=> pause_req_q && pause_zero_q
	) else $error("zero pause not requested below low level");

	AST_HD_NO_PAUSE: assert property ( // [R06]
		!full_duplex && !pause_req_q |=> !pause_req_q
	) else $error("pause requested in half duplex");

	AST_ANY_OFF_NO_PAUSE: assert property ( // [R06]
		!cfg_q.trg_any && !pause_req_q |=> !pause_req_q
	) else $error("pause requested with any-frame mode off");

	AST_PAUSE_NEEDS_HIGH: assert property ( // [R12]
		state_q == FC_IDLE && !above_hi && !pause_req_q |=> !pause_req_q
	) else $error("pause requested below high level");

	AST_LEAVE_FD_IDLE: assert property ( // [R06]
		state_q == FC_PAUSED && !full_duplex |=> state_q == FC_IDLE
	) else $error("paused state kept after leaving full duplex");

	AST_TX_OFF_NO_JAM: assert property ( // [R14]
		!tx_enabled |=> !jam_busy
	) else $error("jam held with transmitter off");

	AST_NO_JAM_BELOW_HI: assert property ( // [R12]
		!above_hi && !jam_busy |=> !jam_busy
	) else $error("jam started below high level");

	AST_JAM_NEEDS_EVENT: assert property ( // [R07]
		!jam_busy && !rx_evt.preamble && !rx_evt.da_valid
		|=> !jam_busy
	) else $error("jam started without a frame event");

	AST_JAM_HOLD: assert property ( // [R01]
		jam_busy && !jam_abort && !tick |=> jam_busy
	) else $error("jam dropped between duration ticks");

	COV_JAM_PREAMBLE: cover property (
		cfg_q.trg_any && jam_start ##1 jam_busy
	);

	COV_JAM_DONE: cover property (
		$fell(jam_busy) && !$past(jam_abort)
	);

	COV_PAUSE_HIGH: cover property (
		$rose(pause_req_q) && !pause_zero_q
	);

	COV_PAUSE_ZERO: cover property (
		$rose(pause_req_q) && pause_zero_q
	);

	COV_ADDR_MATCH: cover property (
		hd_match && jam_start
	);

endmodule // rfc_flow_ctrl

// >>> rtl/rfc_pkg.sv
// Function
// R01: A self-started jam stays on for the time picked by config bits 7:4.
// R02: The jam duration field does nothing while the link runs full duplex.
// R03: Multicast trigger bit 3 jams a multicast frame once the level is hit.
// R04: Broadcast trigger bit 2 jams a broadcast frame once the level is hit.
// R05: Own-address trigger bit 1 jams a frame for this station at the level.
// R06: Any-frame bit 0 jams or pauses on any frame and enables full duplex.
// R07: Half duplex any-frame mode skips address decode and jams on preamble.
// R08: Full duplex any-frame mode asks the MAC for a pause at once.
// R09: The any-frame bit overrides the multicast, broadcast and address bits.
// R10: Durations are 5,10,15,25 us then 50 us steps, plus 2.2 us at 10 Mbps.
// R11: Software keeps the low threshold strictly below the high threshold.
// R12: The high threshold in 64-byte units triggers, one pause per crossing.
// R13: Falling below the low level sends a zero pause only after a pause.
// R14: No pause request and no jam while the transmitter is disabled. A pause request already pending stays up until pause_ack.
package rfc_pkg;

	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned TICK_NS       = 100;
	localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned UNIT_SHIFT = 6;
	localparam int unsigned DUR_W      = 13;

	localparam logic [7:0]  ADDR_CFG  = 8'hAC;
	localparam logic [7:0]  ADDR_STAT = 8'hC0;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_WMASK = 32'h00FF_FFFF;

	// Durations in 0.1 us ticks
	localparam logic [12:0] DUR_C0    = 13'h0032;
	localparam logic [12:0] DUR_C1    = 13'h0064;
	localparam logic [12:0] DUR_C2    = 13'h0096;
	localparam logic [12:0] DUR_C3    = 13'h00FA;
	localparam logic [12:0] DUR_STEP  = 13'h01F4;
	localparam logic [12:0] EXTRA_10M = 13'h0016;
	localparam logic [3:0]  STEP_BASE = 4'h3;

	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] hi_thr;
		logic [7:0] lo_thr;
		logic [3:0] dur_code;
		logic       trg_mcast;
		logic       trg_bcast;
		logic       trg_own;
		logic       trg_any;
	} rfc_cfg_t;

	typedef struct packed {
		logic [15:0] rsvd;
		logic [7:0]  level_units;
		logic [2:0]  rsvd2;
		logic        pause_pending;
		logic        below_lo;
		logic        above_hi;
		logic        paused;
		logic        jam;
	} rfc_stat_t;

	typedef struct packed {
		logic preamble;
		logic da_valid;
		logic mcast;
		logic bcast;
		logic own;
	} rfc_rx_evt_t;

	typedef enum logic [0:0] {
		FC_IDLE   = 1'b0,
		FC_PAUSED = 1'b1
	} rfc_fc_state_t;

	function automatic logic [12:0] rfc_dur_ticks(
		input logic [3:0] code,
		input logic       fast
	);
		logic [12:0] base;
		base = '0;
		unique case (code)
			4'h0: base = DUR_C0;
			4'h1: base = DUR_C1;
			4'h2: base = DUR_C2;
			4'h3: base = DUR_C3;
			default: base = DUR_STEP * 13'(code - STEP_BASE);
		endcase
		return fast ? base : base + EXTRA_10M;
	endfunction

endpackage

// >>> rtl/rfc_tick_div.sv
`timescale 1ns/1ps
module rfc_tick_div #(
	parameter int unsigned CYCLES = rfc_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Control
	input  wire logic clr,
	output logic      tick
);
	import rfc_pkg::*;

	logic [31:0] cnt_q;

	assign tick = (cnt_q == CYCLES - 1);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (clr || tick) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

endmodule // rfc_tick_div

// >>> rtl/rfc_jam_timer.sv
`timescale 1ns/1ps
module rfc_jam_timer (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// Control
	input  wire logic        load,
	input  wire logic [12:0] ticks,
	input  wire logic        abort,
	input  wire logic        tick,
	// State
	output logic             busy_q
);
	import rfc_pkg::*;

	logic [12:0] cnt_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q  <= '0;
			busy_q <= 1'b0;
		end else if (abort) begin
			busy_q <= 1'b0;
		end else if (load) begin
			cnt_q  <= ticks;
			busy_q <= 1'b1;
		end else if (busy_q && tick) begin
			cnt_q  <= cnt_q - 13'h1;
			busy_q <= (cnt_q != 13'h1);
		end
	end

endmodule // rfc_jam_timer

// >>> verification/rfc_mac_model.sv
`timescale 1ns/1ps
module rfc_mac_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Pause request side
	input  wire logic pause_req,
	input  wire logic pause_zero,
	input  wire logic slow,
	output logic      pause_ack,
	// Frames sent
	output int        sent_nz,
	output int        sent_z
);
	int wait_q;

	// Queue until a transmit window opens
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pause_ack <= 1'b0;
			wait_q    <= 0;
			sent_nz   <= 0;
			sent_z    <= 0;
		end else begin
			pause_ack <= 1'b0;
			if (pause_req && !pause_ack) begin
				if (wait_q >= (slow ? 20 : 0)) begin
					pause_ack <= 1'b1;
					wait_q    <= 0;
					if (pause_zero)
						sent_z <= sent_z + 1;
					else
						sent_nz <= sent_nz + 1;
				end else begin
					wait_q <= wait_q + 1;
				end
			end
		end
	end
endmodule // rfc_mac_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	import rfc_pkg::*;

	localparam int TC = 2;
	logic        core_clk;
	logic        rst;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        full_duplex;
	logic        speed_100;
	logic        tx_enabled;
	logic [13:0] rx_fifo_level;
	rfc_rx_evt_t rx_evt;
	logic        jam_req;
	logic        pause_req;
	logic        pause_zero;
	logic        pause_ack;
	logic        slow;
	int          sent_nz;
	int          sent_z;
	int          mismatches;
	int          compares;
	int          cycles;
	int          codes[4] = '{0, 3, 4, 15};
	bit          fast[4] = '{1, 0, 1, 1};

	rfc_flow_ctrl #(.TICK_CYCLES(TC)) u_rfc_flow_ctrl (.core_clk, .rst,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .full_duplex,
		.speed_100, .tx_enabled, .rx_fifo_level, .rx_evt, .jam_req,
		.pause_req, .pause_zero, .pause_ack);
	rfc_mac_model u_rfc_mac_model (.core_clk, .rst, .pause_req,
		.pause_zero, .slow, .pause_ack, .sent_nz, .sent_z);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
		@(posedge core_clk);
	endtask

	// Pulse one event, then measure the jam length
	task automatic ev(input rfc_rx_evt_t e, input int n_exp);
		int n;
		n = 0;
		rx_evt <= e;
		@(posedge core_clk);
		rx_evt <= '0;
		#1;
		while (jam_req === 1'b1 && n < 15000) begin
			@(posedge core_clk);
			#1 n++;
		end
		chk(n, n_exp);
		@(posedge core_clk);
	endtask

	function automatic int dur(input int c, input bit f);
		int b;
		b = (c < 4) ? ((c == 3) ? 250 : 50 * (c + 1)) : 500 * (c - 3);
		return (b + (f ? 0 : 22)) * TC;
	endfunction

	task automatic settle(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	initial begin
		rst = 1'b1;
		{reg_addr, reg_wdata, reg_wr, reg_rd, full_duplex, slow} = '0;
		{speed_100, tx_enabled} = 2'h3;
		rx_fifo_level = 14'h007F;
		rx_evt = '0;
		settle(20);
		rst <= 1'b0;
		settle(1);
		rd(ADDR_CFG, 32'h0000_0000);
		rd(ADDR_STAT, 32'h0000_0104);
		wr(ADDR_CFG, 32'hFFFF_FEFF);
		rd(ADDR_CFG, 32'h00FF_FEFF);
		rd(8'h10, 32'h0000_0000);
		wr(ADDR_CFG, 32'h0002_0101);
		ev(5'h10, 0);
		rx_fifo_level <= 14'h0080;
		ev(5'h10, dur(0, 1));
		for (int k = 0; k < 4; k++) begin
			speed_100 <= fast[k];
			wr(ADDR_CFG, {16'h0002, 8'h01, 4'(codes[k]), 4'h1});
			ev(5'h10, dur(codes[k], fast[k]));
		end
		speed_100 <= 1'b1;
		wr(ADDR_CFG, 32'h0002_0109);
		ev(5'h0C, 0);
		for (int i = 1; i < 4; i++) begin
			wr(ADDR_CFG, {16'h0002, 8'h01, 4'h0, 4'(1 << i)});
			for (int j = 0; j < 3; j++)
				ev(5'(8 | (1 << j)), (i == j + 1) ? dur(0, 1) : 0);
		end
		wr(ADDR_CFG, 32'h0002_0100);
		ev(5'h10, 0);
		tx_enabled <= 1'b0;
		wr(ADDR_CFG, 32'h0002_0101);
		ev(5'h10, 0);
		tx_enabled <= 1'b1;
		rx_evt     <= 5'h10;
		settle(1);
		rx_evt     <= '0;
		settle(3);
		chk(jam_req, 1'b1);
		tx_enabled <= 1'b0;
		settle(2);
		chk(jam_req, 1'b0);
		tx_enabled    <= 1'b1;
		full_duplex   <= 1'b1;
		rx_fifo_level <= 14'h0000;
		wr(ADDR_CFG, 32'h0002_01F1);
		rx_fifo_level <= 14'h0080;
		ev(5'h10, 0);
		settle(40);
		chk(sent_nz, 1);
		chk(sent_z, 0);
		slow          <= 1'b1;
		rx_fifo_level <= 14'h003F;
		settle(60);
		chk(sent_z, 1);
		slow          <= 1'b0;
		tx_enabled    <= 1'b0;
		rx_fifo_level <= 14'h0080;
		settle(40);
		chk(sent_nz, 1);
		rx_fifo_level <= 14'h0000;
		settle(2);
		tx_enabled <= 1'b1;
		wr(ADDR_CFG, 32'h0002_010E);
		rx_fifo_level <= 14'h0080;
		settle(40);
		chk(sent_nz, 1);
		rx_fifo_level <= 14'h0000;
		settle(40);
		chk(sent_z, 1);
		print_verdict();
	end
endmodule // testbench
